/* core/tcs_top.sv */
// transceiver control and status logic with two-wire memory slave
//
// Notes on behaviour
// - transmitter is off while the shutoff pin is high, on while low with soft bit 6 clear and no fault latched.
// - an undriven shutoff pin counts as asserted.
// - transmitter off if shutoff pin or soft bit 6 of byte 110 set.
// - bit 7 of byte 110 shows the shutoff pin level.
// - a catastrophic laser fault raises the fault output and stops the laser.
// - fault output low in normal operation, high on a fault.
// - fault latched until shutoff pin toggles or power cycles.
// - fault state mirrored in bit 2 of byte 110.
// - unsafe optical power shuts the transmitter down.
// - signal-lost output low for good input, high for unusable input.
// - signal-lost state mirrored in bit 1 of byte 110.
// - device address a0 gives 256 identification bytes.
// - device address a2 gives 256 diagnostic bytes incl. control byte.
// - address b0 is reserved for internal test; not answered here.
module tcs_top
  import tcs_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // transmit shutoff pin
  input wire logic tx_disable_i,
  input wire logic tx_disable_driven_i,
  // optics status inputs
  input wire logic laser_fault_detect_i,
  input wire logic eye_unsafe_i,
  input wire logic rx_signal_bad_i,
  // optics controls and status pins
  output logic laser_enable_o,
  output logic tx_fault_o,
  output logic receive_signal_lost_o,
  // two-wire serial interface
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);

  // ==========================================================
  // shutoff, fault and signal-lost state
  logic hw_dis;
  logic hw_dis_q;
  logic next_hw_dis_q;
  logic soft_dis;
  logic next_soft_dis;
  logic fault;
  logic next_fault;
  logic los;
  logic next_los;
  logic laser_en;
  logic next_laser_en;
  logic ctrl_wr;
  logic [7:0] ctrl_wdata;

  // undriven pin reads as high through the internal pull-up
  assign hw_dis = tx_disable_i | ~tx_disable_driven_i;

  always_comb begin
    next_hw_dis_q = hw_dis;
    next_soft_dis = soft_dis;
    if (ctrl_wr) begin
      next_soft_dis = ctrl_wdata[SOFT_DIS_BIT];
    end
    next_fault = fault;
    // a release of the shutoff pin after it was high clears the latch
    if (hw_dis_q && !hw_dis) begin
      next_fault = 1'b0;
    end
    // a new fault wins over the clear
    if (laser_fault_detect_i || eye_unsafe_i) begin
      next_fault = 1'b1;
    end
    next_los = rx_signal_bad_i;
    next_laser_en = ~(hw_dis | soft_dis | next_fault);
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hw_dis_q <= 1'b1;
      soft_dis <= SOFT_DIS_RESET;
      fault <= 1'b0;
      los <= 1'b1;
      laser_en <= 1'b0;
    end else begin
      hw_dis_q <= next_hw_dis_q;
      soft_dis <= next_soft_dis;
      fault <= next_fault;
      los <= next_los;
      laser_en <= next_laser_en;
    end
  end

  assign laser_enable_o = laser_en;
  assign tx_fault_o = fault;
  assign receive_signal_lost_o = los;

  // ==========================================================
  // memories
  // identification page in the lower half, diagnostic page in the upper half
  // no reset contents: cells behave like the serial memory they stand for
  // the control byte cell of the diagnostic page is never written or read
  logic [7:0] mem [MEM_WORDS * 2];
  logic mem_wr;
  logic [8:0] mem_waddr;
  logic [7:0] mem_wdata;

  always_ff @(posedge clk_i) begin
    if (mem_wr) begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  // diagnostic space holds the live control byte at its offset
  function automatic logic [7:0] read_byte(input logic sel, input logic [7:0] offs);
    logic [7:0] b;
    b = mem[{sel, offs}];
    if (sel && offs == LINK_CTRL_OFFS) begin
      b = 8'h00;
      b[HW_DIS_BIT] = hw_dis_q;
      b[SOFT_DIS_BIT] = soft_dis;
      b[FAULT_BIT] = fault;
      b[LOS_BIT] = los;
    end
    return b;
  endfunction : read_byte

  // ==========================================================
  // two-wire slave
  // both lines are oversampled on clk_i, so each scl level must last
  // at least two clocks for a clean edge to be seen
  // bits are taken at an scl rise and changed one clock after an scl fall,
  // which keeps sda steady for the whole high phase of scl
  // a start or stop seen in any state restarts or parks the engine,
  // so a master that gives up mid-byte never leaves the line held low
  // the acknowledge is driven for exactly one scl period after each byte received
  // an address outside the two memory pages is never acknowledged

  // the two memory pages differ only in bit 1; bit 0 is the read flag
  function automatic logic is_mem_page(input logic [7:0] dev);
    return {dev[7:2], 2'b00} == ID_DEV_ADDR;
  endfunction : is_mem_page

  tcs_state_type state;
  tcs_state_type next_state;
  tcs_state_type after;
  tcs_state_type next_after;
  logic scl_q;
  logic sda_q;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [7:0] offs;
  logic [7:0] next_offs;
  logic sel;
  logic next_sel;
  logic drive;
  logic next_drive;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic byte_done;

  assign scl_rise = scl_i & ~scl_q;
  assign scl_fall = ~scl_i & scl_q;
  assign start_seen = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_seen = scl_i & scl_q & ~sda_q & sda_i;
  assign byte_done = bitcnt == BITS_PER_BYTE;

  always_comb begin
    next_state = state;
    next_after = after;
    next_bitcnt = bitcnt;
    next_shift = shift;
    next_offs = offs;
    next_sel = sel;
    next_drive = drive;
    mem_wr = 1'b0;
    mem_waddr = {sel, offs};
    mem_wdata = shift;
    ctrl_wr = 1'b0;
    ctrl_wdata = shift;
    if (start_seen) begin
      next_state = ST_DEV;
      next_bitcnt = 4'h0;
      next_drive = 1'b0;
    end else if (stop_seen) begin
      next_state = ST_IDLE;
      next_drive = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_drive = 1'b0;
        end
        ST_DEV, ST_OFFS, ST_WDATA: begin
          if (scl_rise && !byte_done) begin
            next_shift = {shift[6:0], sda_i};
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && byte_done) begin
            next_bitcnt = 4'h0;
            next_drive = 1'b1;
            next_state = ST_ACK;
            if (state == ST_DEV) begin
              // only the two memory pages answer; b0 and others stay silent
              if (!is_mem_page(shift)) begin
                next_drive = 1'b0;
                next_state = ST_IDLE;
              end else begin
                next_sel = shift[1];
                next_drive = 1'b1;
                next_after = shift[0] ? ST_RDATA : ST_OFFS;
              end
            end else if (state == ST_OFFS) begin
              next_offs = shift;
              next_after = ST_WDATA;
            end else begin
              if (sel && offs == LINK_CTRL_OFFS) begin
                ctrl_wr = 1'b1;
              end else begin
                mem_wr = 1'b1;
              end
              next_offs = offs + 8'h01;
              next_after = ST_WDATA;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            next_bitcnt = 4'h0;
            next_state = after;
            next_drive = 1'b0;
            if (after == ST_RDATA) begin
              next_shift = read_byte(sel, offs);
              next_drive = ~next_shift[7];
            end
          end
        end
        ST_RDATA: begin
          if (scl_rise && !byte_done) begin
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && byte_done) begin
            next_bitcnt = 4'h0;
            next_drive = 1'b0;
            next_offs = offs + 8'h01;
            next_state = ST_MACK;
          end else if (scl_fall) begin
            next_shift = {shift[6:0], 1'b0};
            next_drive = ~next_shift[7];
          end
        end
        ST_MACK: begin
          // master acknowledge keeps the read going, a refusal ends it
          if (scl_rise) begin
            next_state = sda_i ? ST_IDLE : ST_ACK;
            next_after = ST_RDATA;
          end
        end
        default: begin
          next_state = ST_IDLE;
          next_drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_IDLE;
      after <= ST_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bitcnt <= 4'h0;
      shift <= 8'h00;
      offs <= 8'h00;
      sel <= 1'b0;
      drive <= 1'b0;
    end else begin
      state <= next_state;
      after <= next_after;
      scl_q <= scl_i;
      sda_q <= sda_i;
      bitcnt <= next_bitcnt;
      shift <= next_shift;
      offs <= next_offs;
      sel <= next_sel;
      drive <= next_drive;
    end
  end

  // open-drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = drive;

endmodule : tcs_top

/* core/tcs_pkg.sv */
// constants and types for the transceiver control and status block
package tcs_pkg;

  // ==========================================================
  // serial device addresses (8-bit form, r/w bit clear)
  localparam logic [7:0] ID_DEV_ADDR = 8'ha0;
  localparam logic [7:0] DIAG_DEV_ADDR = 8'ha2;
  localparam logic [7:0] TEST_DEV_ADDR = 8'hb0;

  // ==========================================================
  // link control and status byte in diagnostic memory
  localparam logic [7:0] LINK_CTRL_OFFS = 8'h6e;
  localparam int HW_DIS_BIT = 7;
  localparam int SOFT_DIS_BIT = 6;
  localparam int FAULT_BIT = 2;
  localparam int LOS_BIT = 1;
  localparam logic SOFT_DIS_RESET = 1'b0;

  // ==========================================================
  // serial engine
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [8:0] MEM_WORDS = 9'h100;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_OFFS,
    ST_WDATA,
    ST_ACK,
    ST_RDATA,
    ST_MACK
  } tcs_state_type;

endpackage : tcs_pkg

/* bench/tcs_chk.sv */
// port checker for the transceiver control and status block
module tcs_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // optics pins
  input wire logic tx_disable_i,
  input wire logic tx_disable_driven_i,
  input wire logic laser_fault_detect_i,
  input wire logic eye_unsafe_i,
  input wire logic rx_signal_bad_i,
  input wire logic laser_enable_o,
  input wire logic tx_fault_o,
  input wire logic receive_signal_lost_o,
  // serial lines
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic hw_dis = tx_disable_i | ~tx_disable_driven_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ==========================================================
  // optics pins
  pin_off_a: assert property (hw_dis |=> !laser_enable_o)
    else $error("laser on while shutoff asserted");
  fault_off_a: assert property (tx_fault_o |-> !laser_enable_o)
    else $error("laser on during fault");
  fault_set_a: assert property (laser_fault_detect_i |=> tx_fault_o)
    else $error("fault not raised");
  fault_idle_a: assert property (!tx_fault_o && !laser_fault_detect_i && !eye_unsafe_i |=> !tx_fault_o)
    else $error("fault raised without cause");
  fault_hold_a: assert property (tx_fault_o && !$fell(hw_dis) |=> tx_fault_o)
    else $error("fault dropped without toggle");
  fault_clr_a: assert property ($fell(hw_dis) && !laser_fault_detect_i && !eye_unsafe_i |=> !tx_fault_o)
    else $error("fault kept after toggle");
  eye_off_a: assert property (eye_unsafe_i |=> !laser_enable_o)
    else $error("laser on while unsafe");
  los_copy_a: assert property (rst_b_i |=> receive_signal_lost_o == $past(rx_signal_bad_i))
    else $error("signal lost pin wrong");
  // ==========================================================
  // serial lines
  open_drain_a: assert property (!sda_o)
    else $error("data driven high");
  sda_edge_a: assert property ($changed(sda_oe_o) |-> $past(scl_i, 2) && !$past(scl_i))
    else $error("data changed off clock fall");
  cover property (laser_fault_detect_i ##1 tx_fault_o);
  cover property ($fell(tx_fault_o));
  cover property ($rose(sda_oe_o));
endmodule : tcs_chk

/* bench/tcs_host.sv */
// host board model: two-wire master pulling the data line low
module tcs_host (
  // clock
  input wire logic clk_i,
  // serial lines
  input wire logic sda_i,
  output logic scl_o,
  output logic pull_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  task automatic wt();
    repeat (3) @(negedge clk_i);
  endtask : wt
  // also a repeated start from a low clock
  task automatic start();
    wt();
    pull_o = 1'b0;
    wt();
    scl_o = 1'b1;
    wt();
    pull_o = 1'b1;
    wt();
    scl_o = 1'b0;
  endtask : start
  task automatic stop();
    wt();
    pull_o = 1'b1;
    wt();
    scl_o = 1'b1;
    wt();
    pull_o = 1'b0;
    wt();
  endtask : stop
  task automatic sbit(input logic b, output logic r);
    wt();
    pull_o = ~b;
    wt();
    scl_o = 1'b1;
    wt();
    r = sda_i;
    scl_o = 1'b0;
  endtask : sbit
  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) sbit(d[i], q[i]);
    sbit(m, k);
  endtask : xfer
endmodule : tcs_host

/* bench/testbench.sv */
// self-checking bench for the transceiver control and status block
module testbench;
  import tcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_b_i = 0, tx_disable_i = 0, tx_disable_driven_i = 0;
  logic laser_fault_detect_i = 0, eye_unsafe_i = 0, rx_signal_bad_i = 0;
  logic laser_enable_o, tx_fault_o, receive_signal_lost_o, sda_o, sda_oe_o, scl_i, pull;
  logic [7:0] a, d, q;
  logic k;
  int fail_count = 0, checks_done = 0;
  wire logic sda_i = ~(pull | sda_oe_o);
  tcs_top dut (.clk_i, .rst_b_i, .tx_disable_i, .tx_disable_driven_i, .laser_fault_detect_i,
    .eye_unsafe_i, .rx_signal_bad_i, .laser_enable_o, .tx_fault_o, .receive_signal_lost_o,
    .scl_i, .sda_i, .sda_o, .sda_oe_o);
  tcs_host host (.clk_i, .sda_i, .scl_o(scl_i), .pull_o(pull));
  // ==========================================================
  // checking helpers
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  function automatic logic [7:0] stat(input logic s, input logic f);
    stat = 8'h00;
    stat[HW_DIS_BIT] = tx_disable_i | ~tx_disable_driven_i;
    stat[SOFT_DIS_BIT] = s;
    stat[FAULT_BIT] = f;
    stat[LOS_BIT] = rx_signal_bad_i;
  endfunction : stat
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc
  // reserved address must see every byte refused
  task automatic wr(input logic [7:0] dv, input logic [7:0] o, input logic [7:0] v);
    logic e;
    e = (dv == TEST_DEV_ADDR);
    host.start();
    host.xfer(dv, 1'b1, q, k);
    chk("dev ack", k, e);
    host.xfer(o, 1'b1, q, k);
    chk("offs ack", k, e);
    host.xfer(v, 1'b1, q, k);
    chk("data ack", k, e);
    host.stop();
  endtask : wr
  task automatic rd(input logic [7:0] dv, input logic [7:0] o, output logic [7:0] r);
    host.start();
    host.xfer(dv, 1'b1, q, k);
    host.xfer(o, 1'b1, q, k);
    host.start();
    host.xfer(dv | 8'h01, 1'b1, q, k);
    chk("rd ack", k, 0);
    host.xfer(8'hff, 1'b1, r, k);
    host.stop();
  endtask : rd
  // ==========================================================
  // clock, watchdog and scenarios
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    fail_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h66e1c53b));
    cyc(5);
    rst_b_i = 1;
    cyc(2);
    chk("undriven", laser_enable_o, 0);
    tx_disable_driven_i = 1;
    repeat (12) begin
      {tx_disable_i, rx_signal_bad_i} = 2'($urandom);
      cyc(2);
      chk("laser", laser_enable_o, !tx_disable_i);
      chk("los", receive_signal_lost_o, rx_signal_bad_i);
      rd(DIAG_DEV_ADDR, LINK_CTRL_OFFS, d);
      chk("status", d, stat(0, 0));
    end
    tx_disable_i = 0;
    wr(DIAG_DEV_ADDR, LINK_CTRL_OFFS, 8'h40);
    cyc(2);
    chk("soft off", laser_enable_o, 0);
    laser_fault_detect_i = 1;
    cyc(1);
    laser_fault_detect_i = 0;
    cyc(1);
    chk("fault", tx_fault_o, 1);
    wr(DIAG_DEV_ADDR, LINK_CTRL_OFFS, 8'h00);
    cyc(2);
    chk("latched", {tx_fault_o, laser_enable_o}, 2'b10);
    rd(DIAG_DEV_ADDR, LINK_CTRL_OFFS, d);
    chk("fault stat", d, stat(0, 1));
    tx_disable_i = 1; // shutoff spacing is host advice; design does not rely on it
    cyc(2);
    tx_disable_i = 0;
    cyc(2);
    chk("cleared", {tx_fault_o, laser_enable_o}, 2'b01);
    eye_unsafe_i = 1;
    cyc(2);
    chk("eye", laser_enable_o, 0);
    eye_unsafe_i = 0;
    tx_disable_i = 1;
    cyc(2);
    tx_disable_i = 0;
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 8'hff : 8'($urandom);
      d = 8'($urandom);
      if (a == LINK_CTRL_OFFS) a = 8'h00;
      wr(ID_DEV_ADDR, a, d);
      wr(DIAG_DEV_ADDR, a, ~d);
      rd(ID_DEV_ADDR, a, q);
      chk("id mem", q, d);
      rd(DIAG_DEV_ADDR, a, q);
      chk("diag mem", q, ~d);
    end
    wr(TEST_DEV_ADDR, 8'h00, 8'h00);
    wrap_up();
  end
endmodule : testbench
bind tcs_top tcs_chk chk (.clk_i, .rst_b_i, .tx_disable_i, .tx_disable_driven_i,
  .laser_fault_detect_i, .eye_unsafe_i, .rx_signal_bad_i, .laser_enable_o, .tx_fault_o,
  .receive_signal_lost_o, .scl_i, .sda_i, .sda_o, .sda_oe_o);
